// ==== design/lcf_deglitch.sv ====
// Persistence filter: output rises once the input has stayed high for a set number of cycles.
`timescale 1ns/10ps
module lcf_deglitch
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Filter
  input wire logic raw,
  input wire logic [31:0] limit,
  output logic hit
);
  lcf_pkg::lcf_dg_regs_t r_r;
  lcf_pkg::lcf_dg_regs_t r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    if (!raw)
    begin
      r_nxt.cnt = 32'h0000_0000;
      r_nxt.hit = 1'b0;
    end
    else if (r_r.cnt + 32'h0000_0001 >= limit)
    begin
      r_nxt.hit = 1'b1;
    end
    else
    begin
      r_nxt.cnt = r_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign hit = r_r.hit;
endmodule // lcf_deglitch

// ==== design/lcf_map.svh ====
// Register map, field positions, reset values and timing figures of the lock current fault handler.
`ifndef LCF_MAP_SVH
`define LCF_MAP_SVH
// ==========================================================================
// Register indices and byte addresses
`define LCF_SETUP_ONE_IDX 12'h090
`define LCF_ADDR_SETUP_ONE (`LCF_SETUP_ONE_IDX << 2)
`define LCF_ADDR_STATUS 12'h250
`define LCF_ADDR_CLEAR 12'h254
`define LCF_ADDR_ENABLE 12'h258
`define LCF_ADDR_RETRY_LIM 12'h25C
`define LCF_ADDR_CTRL 12'h260
`define LCF_ADDR_STATE 12'h264
// ==========================================================================
// Field positions of fault_setup_one
`define LCF_F_ILIM_LSB 27
`define LCF_F_CTHR_LSB 23
`define LCF_F_ATHR_LSB 19
`define LCF_F_MODE_LSB 15
`define LCF_F_DEG_LSB 11
`define LCF_F_RWAIT_LSB 7
// ==========================================================================
// Reset values
`define LCF_SETUP_ONE_RST 31'h0000_0000
`define LCF_RETRY_LIM_RST 4'h0
// ==========================================================================
// Timing figures
`define LCF_CLK_NS 5
`define LCF_DEG_UNIT_NS 50000
`define LCF_RETRY_UNIT_NS 100000000
`endif

// ==== design/lcf_pkg.sv ====
// Types shared by the lock current fault handler.
package lcf_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RETRY = 2'b01,
    ST_LATCH = 2'b11,
    ST_REPORT = 2'b10
  } lcf_state_t;
  typedef enum logic [1:0] {
    DRV_NONE = 2'b00,
    DRV_HIZ = 2'b01,
    DRV_BRK_HI = 2'b10,
    DRV_BRK_LO = 2'b11
  } lcf_drive_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic hit;
  } lcf_dg_regs_t;
  typedef struct packed {
    logic [30:0] cfg;
    logic [2:0] sts;
    logic [2:0] en;
    logic [3:0] rlim;
    lcf_state_t st;
    lcf_drive_t drv;
    logic [3:0] rcnt;
    logic [31:0] tmr;
    logic fault_n;
    logic hiz;
    logic bhi;
    logic blo;
    logic irq;
    logic [3:0] ilim;
    logic [3:0] cthr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lcf_regs_t;
endpackage

// ==== design/lcf_top.sv ====
// Lock current fault handler with APB registers, retry timing and fault drive outputs.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "lcf_map.svh"

// Function
// - The torque loop current reference is the 4-bit code of bits 30-27, with 0h to Dh valid and Eh, Fh reserved.
// - The comparator lock threshold is the 4-bit code of bits 26-23 on the same current scale, Eh and Fh reserved.
// - ADC current is compared with the threshold chosen by bits 22-19 on the same scale, Eh and Fh reserved.
// - Modes 0h and 1h latch the fault, assert fault_out_n and tristate all gate outputs on a lock.
// - Mode 2h latches the fault, asserts fault_out_n and brakes with all high-side switches on.
// - Mode 3h latches the fault, asserts fault_out_n and brakes with all low-side switches on.
// - Modes 4h and 5h tristate and assert the fault, clear it after the retry wait, and latch past the limit.
// - Mode 6h brakes high, asserts the fault and clears it after each retry wait up to the retry limit.
// - Mode 7h brakes low, asserts the fault, retries after each wait and latches past the retry limit.
// - Mode 8h only reports a lock on fault_out_n and leaves the gate outputs untouched.
// - Modes 9h, Ah and Ch disable lock detection and never raise a fault.
// - A lock counts only after persisting for the deglitch time of bits 14-11, 0.05 ms to 1000 ms.
// - The retry wait comes from bits 10-7, 300 ms at 0h rising to 14 s at Fh.
module lcf_top
#(
  parameter int unsigned DEG_UNIT_CYC = `LCF_DEG_UNIT_NS / `LCF_CLK_NS,
  parameter int unsigned RETRY_UNIT_CYC = `LCF_RETRY_UNIT_NS / `LCF_CLK_NS,
  parameter int unsigned ADC_W = 12,
  parameter int unsigned ADC_FRAC = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Current sensing
  input wire logic comp_trip,
  input wire logic [ADC_W-1:0] adc_current,
  output logic [3:0] comparator_lock_threshold,
  output logic [3:0] ilimit_ref,
  // Power stage
  output logic fault_out_n,
  output logic gate_hiz,
  output logic brake_high,
  output logic brake_low,
  // Interrupt
  output logic irq
);
  // ==========================================================================
  // Code tables
  // Current steps are multiples of 0.078125 A.
  function automatic logic [5:0] cur_steps(input logic [3:0] c);
    case (c)
      4'h0: cur_steps = 6'h01;
      4'h1: cur_steps = 6'h02;
      4'h2: cur_steps = 6'h04;
      4'h3: cur_steps = 6'h08;
      default: cur_steps = 6'(({2'h0, c} - 6'h01) * 6'h04);
    endcase
  endfunction

  // Deglitch times in units of 0.05 ms.
  function automatic logic [31:0] deg_units(input logic [3:0] c);
    case (c)
      4'h0: deg_units = 32'h0000_0001;
      4'h1: deg_units = 32'h0000_0002;
      4'h2: deg_units = 32'h0000_0004;
      4'h3: deg_units = 32'h0000_000A;
      4'h4: deg_units = 32'h0000_0014;
      4'h5: deg_units = 32'h0000_0032;
      4'h6: deg_units = 32'h0000_0064;
      4'h7: deg_units = 32'h0000_0096;
      4'h8: deg_units = 32'h0000_00C8;
      4'h9: deg_units = 32'h0000_01F4;
      4'hA: deg_units = 32'h0000_03E8;
      4'hB: deg_units = 32'h0000_05DC;
      4'hC: deg_units = 32'h0000_07D0;
      4'hD: deg_units = 32'h0000_0FA0;
      4'hE: deg_units = 32'h0000_2710;
      default: deg_units = 32'h0000_4E20;
    endcase
  endfunction

  // Retry waits in units of 100 ms.
  function automatic logic [31:0] retry_units(input logic [3:0] c);
    case (c)
      4'h0: retry_units = 32'h0000_0003;
      4'h1: retry_units = 32'h0000_0005;
      default: retry_units = 32'(c - 4'h1) * 32'h0000_000A;
    endcase
  endfunction

  // ==========================================================================
  // State and decode
  lcf_pkg::lcf_regs_t r_r;
  lcf_pkg::lcf_regs_t r_nxt;
  logic [3:0] mode;
  logic [3:0] athr;
  logic detect_en;
  logic adc_over;
  logic raw_lock;
  logic lock_q;
  logic [63:0] deg_prod;
  logic [63:0] retry_prod;
  logic [31:0] deg_limit;
  logic [31:0] retry_cyc;
  logic acc;
  logic wr;
  logic clr_fault;
  logic [2:0] sts_set;

  assign mode = r_r.cfg[`LCF_F_MODE_LSB +: 4];
  assign athr = r_r.cfg[`LCF_F_ATHR_LSB +: 4];
  // Only the listed modes 0h to 8h arm detection; everything else is treated as off.
  assign detect_en = (mode <= 4'h8);
  assign adc_over = (athr <= 4'hD) && (adc_current >= (ADC_W'(cur_steps(athr)) << ADC_FRAC));
  // The held comparator code is never reserved, so the written code decides whether that detector is on.
  assign raw_lock = detect_en && (adc_over || (comp_trip && (r_r.cfg[`LCF_F_CTHR_LSB +: 4] <= 4'hD)));
  assign deg_prod = 64'(deg_units(r_r.cfg[`LCF_F_DEG_LSB +: 4])) * 64'(DEG_UNIT_CYC);
  assign deg_limit = deg_prod[31:0];
  assign retry_prod = 64'(retry_units(r_r.cfg[`LCF_F_RWAIT_LSB +: 4])) * 64'(RETRY_UNIT_CYC);
  assign retry_cyc = retry_prod[31:0];

  lcf_deglitch u_deg
  (
    .clk(clk),
    .arst_n(arst_n),
    .raw(raw_lock),
    .limit(deg_limit),
    .hit(lock_q)
  );

  assign acc = psel && penable && r_r.pready;
  assign wr = acc && pwrite;
  assign clr_fault = wr && (paddr == `LCF_ADDR_CTRL) && pwdata[0];

  // ==========================================================================
  // Next state
  always_comb
  begin
    r_nxt = r_r;
    sts_set = 3'h0;
    // Register writes land in the access phase; the answer is prepared in setup.
    r_nxt.pready = psel && !penable;
    if (psel && !penable)
    begin
      r_nxt.pslverr = 1'b0;
      r_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `LCF_ADDR_SETUP_ONE: r_nxt.prdata = {1'b0, r_r.cfg};
        `LCF_ADDR_STATUS: r_nxt.prdata = {29'h0, r_r.sts};
        `LCF_ADDR_ENABLE: r_nxt.prdata = {29'h0, r_r.en};
        `LCF_ADDR_RETRY_LIM: r_nxt.prdata = {28'h0, r_r.rlim};
        `LCF_ADDR_STATE: r_nxt.prdata = {22'h0, !r_r.fault_n, lock_q, r_r.rcnt, r_r.drv, r_r.st};
        `LCF_ADDR_CLEAR, `LCF_ADDR_CTRL: r_nxt.prdata = 32'h0000_0000;
        default: r_nxt.pslverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        `LCF_ADDR_SETUP_ONE: r_nxt.cfg = pwdata[30:0];
        `LCF_ADDR_ENABLE: r_nxt.en = pwdata[2:0];
        `LCF_ADDR_RETRY_LIM: r_nxt.rlim = pwdata[3:0];
        default: r_nxt.cfg = r_nxt.cfg;
      endcase
    end
    // Reserved codes leave the last valid reference in place.
    if (r_r.cfg[`LCF_F_ILIM_LSB +: 4] <= 4'hD)
      r_nxt.ilim = r_r.cfg[`LCF_F_ILIM_LSB +: 4];
    if (r_r.cfg[`LCF_F_CTHR_LSB +: 4] <= 4'hD)
      r_nxt.cthr = r_r.cfg[`LCF_F_CTHR_LSB +: 4];

    case (r_r.st)
      lcf_pkg::ST_IDLE:
      begin
        if (clr_fault)
          r_nxt.rcnt = 4'h0;
        if (lock_q && detect_en)
        begin
          sts_set[0] = 1'b1;
          if (mode <= 4'h3)
          begin
            r_nxt.st = lcf_pkg::ST_LATCH;
            sts_set[1] = 1'b1;
            case (mode)
              4'h2: r_nxt.drv = lcf_pkg::DRV_BRK_HI;
              4'h3: r_nxt.drv = lcf_pkg::DRV_BRK_LO;
              default: r_nxt.drv = lcf_pkg::DRV_HIZ;
            endcase
          end
          else if (mode <= 4'h7)
          begin
            case (mode)
              4'h6: r_nxt.drv = lcf_pkg::DRV_BRK_HI;
              4'h7: r_nxt.drv = lcf_pkg::DRV_BRK_LO;
              default: r_nxt.drv = lcf_pkg::DRV_HIZ;
            endcase
            // One more fault than the limit allows stops the retries until a control clear.
            if (r_r.rcnt >= r_r.rlim)
            begin
              r_nxt.st = lcf_pkg::ST_LATCH;
              sts_set[1] = 1'b1;
            end
            else
            begin
              r_nxt.st = lcf_pkg::ST_RETRY;
              r_nxt.rcnt = r_r.rcnt + 4'h1;
              r_nxt.tmr = retry_cyc - 32'h0000_0001;
            end
          end
          else
          begin
            r_nxt.st = lcf_pkg::ST_REPORT;
            r_nxt.drv = lcf_pkg::DRV_NONE;
          end
        end
      end
      lcf_pkg::ST_RETRY:
      begin
        if (r_r.tmr == 32'h0000_0000)
        begin
          r_nxt.st = lcf_pkg::ST_IDLE;
          r_nxt.drv = lcf_pkg::DRV_NONE;
          sts_set[2] = 1'b1;
        end
        else
        begin
          r_nxt.tmr = r_r.tmr - 32'h0000_0001;
        end
      end
      lcf_pkg::ST_LATCH:
      begin
        if (clr_fault)
        begin
          r_nxt.st = lcf_pkg::ST_IDLE;
          r_nxt.drv = lcf_pkg::DRV_NONE;
          r_nxt.rcnt = 4'h0;
        end
      end
      lcf_pkg::ST_REPORT:
      begin
        if (!lock_q || !detect_en)
          r_nxt.st = lcf_pkg::ST_IDLE;
      end
      default:
      begin
        r_nxt.st = lcf_pkg::ST_IDLE;
        r_nxt.drv = lcf_pkg::DRV_NONE;
      end
    endcase

    // A new event outranks a clear written in the same cycle.
    if (wr && (paddr == `LCF_ADDR_CLEAR))
      r_nxt.sts = r_r.sts & ~pwdata[2:0];
    r_nxt.sts = r_nxt.sts | sts_set;
    r_nxt.irq = |(r_nxt.sts & r_nxt.en);
    r_nxt.fault_n = (r_nxt.st == lcf_pkg::ST_IDLE);
    r_nxt.hiz = (r_nxt.drv == lcf_pkg::DRV_HIZ);
    r_nxt.bhi = (r_nxt.drv == lcf_pkg::DRV_BRK_HI);
    r_nxt.blo = (r_nxt.drv == lcf_pkg::DRV_BRK_LO);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_r <= '0;
      r_r.cfg <= `LCF_SETUP_ONE_RST;
      r_r.rlim <= `LCF_RETRY_LIM_RST;
      r_r.fault_n <= 1'b1;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign comparator_lock_threshold = r_r.cthr;
  assign ilimit_ref = r_r.ilim;
  assign fault_out_n = r_r.fault_n;
  assign gate_hiz = r_r.hiz;
  assign brake_high = r_r.bhi;
  assign brake_low = r_r.blo;
  assign irq = r_r.irq;

  // ==========================================================================
  // Checks
  chk_ref_valid: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($past(r_r.cfg[`LCF_F_ILIM_LSB +: 4]) <= 4'hD) |-> (ilimit_ref == $past(r_r.cfg[`LCF_F_ILIM_LSB +: 4])))
    else $error("current reference does not follow its code");
  chk_cthr_reserved: assert property (
    @(posedge clk) disable iff (!arst_n)
    comparator_lock_threshold == (($past(r_r.cfg[`LCF_F_CTHR_LSB +: 4]) <= 4'hD) ?
      $past(r_r.cfg[`LCF_F_CTHR_LSB +: 4]) : $past(comparator_lock_threshold)))
    else $error("comparator threshold holds a reserved code");
  chk_adc_compare: assert property (
    @(posedge clk) disable iff (!arst_n)
    (detect_en && athr == 4'h9 && adc_current >= (ADC_W'(32) << ADC_FRAC)) |-> raw_lock)
    else $error("adc threshold not applied");
  chk_latch_hiz: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && lock_q && mode <= 4'h1) |=> (!fault_out_n && gate_hiz && !brake_high) [*2])
    else $error("latched tristate response missing");
  chk_latch_hbrake: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && lock_q && mode == 4'h2) |=> (r_r.st == lcf_pkg::ST_LATCH && brake_high && !gate_hiz))
    else $error("high brake response missing");
  chk_latch_lbrake: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && lock_q && mode == 4'h3) |=> (r_r.st == lcf_pkg::ST_LATCH && brake_low && !fault_out_n))
    else $error("low brake response missing");
  chk_retry_end: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_RETRY && r_r.tmr == 32'h0000_0000) |=> (fault_out_n && !gate_hiz && !brake_low))
    else $error("retry wait did not clear the fault");
  chk_retry_limit: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && lock_q && mode == 4'h7 && r_r.rcnt >= r_r.rlim) |=> (r_r.st == lcf_pkg::ST_LATCH && brake_low))
    else $error("retry limit did not latch");
  chk_retry_hbrake: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && lock_q && mode == 4'h6 && r_r.rcnt < r_r.rlim) |=> (r_r.st == lcf_pkg::ST_RETRY && brake_high && r_r.rcnt == $past(r_r.rcnt) + 4'h1))
    else $error("high brake retry missing");
  chk_report_only: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_REPORT) |-> (!fault_out_n && !gate_hiz && !brake_high && !brake_low))
    else $error("report mode touched gate outputs");
  chk_mode_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    (mode == 4'h9 || mode == 4'hA || mode == 4'hC) |-> !raw_lock)
    else $error("disabled mode still detects");
  chk_undef_off: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && mode > 4'hA && mode != 4'hC) |=> fault_out_n)
    else $error("undefined mode raised a fault");
  chk_deg_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(lock_q) |-> $past(raw_lock) && $past(raw_lock, 2))
    else $error("lock reported without persistence");
  chk_wait_load: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_IDLE && $past(r_r.st) == lcf_pkg::ST_IDLE) ##1 (r_r.st == lcf_pkg::ST_RETRY)
    |-> r_r.tmr == $past(retry_cyc) - 32'h0000_0001)
    else $error("retry timer loaded with wrong wait");
  chk_count_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    (r_r.st == lcf_pkg::ST_LATCH && clr_fault) |=> (r_r.rcnt == 4'h0 && fault_out_n))
    else $error("retry count not cleared");
endmodule // lcf_top

// ==== sim/lcf_stage_model.sv ====
// Behavioural power stage and current sensing on the far side of the fault handler.
`timescale 1ns/10ps
// ==========================================================================
// Stage model
module lcf_stage_model
(
  // Load current wanted by the bench, in ADC steps
  input wire logic [11:0] load_lsb,
  // Drive commands from the handler
  input wire logic gate_hiz,
  input wire logic brake_high,
  input wire logic brake_low,
  input wire logic [3:0] comparator_lock_threshold,
  // Sensed current
  output logic comp_trip,
  output logic [11:0] adc_current
);
  logic [11:0] lim;
  // A tristated or braked bridge draws no supply current, so a lock goes away while the stage is off.
  // A reserved comparator code never trips; the real level there is undefined.
  always_comb
  begin
    adc_current = (gate_hiz || brake_high || brake_low) ? 12'h000 : load_lsb;
    if (comparator_lock_threshold < 4'h4)
      lim = 12'h010 << comparator_lock_threshold;
    else
      lim = 12'(64 * (int'(comparator_lock_threshold) - 1));
    comp_trip = (comparator_lock_threshold <= 4'hD) && (adc_current >= lim);
  end
endmodule // lcf_stage_model

// ==== sim/lcf_top_tb.sv ====
// Self-checking testbench of the lock current fault handler.
`timescale 1ns/10ps
`include "lcf_map.svh"
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
// ==========================================================================
// Bench
module lcf_top_tb;
  localparam int DEG = 2;
  localparam int RET = 4;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, comp_trip, err;
  logic fault_out_n, gate_hiz, brake_high, brake_low, irq;
  logic [11:0] paddr, adc_current, load;
  logic [31:0] pwdata, prdata, q, w;
  logic [3:0] comparator_lock_threshold, ilimit_ref, c;
  int i, m, k, errors, n_tests, cyc;

  lcf_top #(.DEG_UNIT_CYC(DEG), .RETRY_UNIT_CYC(RET)) lcf_top_inst
  (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_trip(comp_trip),
    .adc_current(adc_current), .comparator_lock_threshold(comparator_lock_threshold),
    .ilimit_ref(ilimit_ref), .fault_out_n(fault_out_n), .gate_hiz(gate_hiz),
    .brake_high(brake_high), .brake_low(brake_low), .irq(irq)
  );
  lcf_stage_model lcf_stage_model_inst
  (
    .load_lsb(load), .gate_hiz(gate_hiz), .brake_high(brake_high), .brake_low(brake_low),
    .comparator_lock_threshold(comparator_lock_threshold), .comp_trip(comp_trip),
    .adc_current(adc_current)
  );

  // ==========================================================================
  // Expectations
  function automatic logic [31:0] cfg(input logic [3:0] il, ct, at, md, dg, rw);
    return {1'b0, il, ct, at, md, dg, rw, 7'h00};
  endfunction
  function automatic logic [11:0] thr(input logic [3:0] cd);
    return 12'((cd < 4 ? (1 << cd) : 4 * (int'(cd) - 1)) * 16);
  endfunction

  // ==========================================================================
  // Bus and timing helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000)
      begin
        errors++;
        $display("timeout");
        report_and_stop();
      end
    end
  end

  // ==========================================================================
  // Tests
  initial
  begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, load} = '0;
    errors = 0;
    n_tests = 0;
    void'($urandom(27));
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("fault_out_n in reset", 1'b1, fault_out_n)
    @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `LCF_ADDR_SETUP_ONE, 32'h0);
    `CHK("setup reset", 32'h0, q)
    apb(1'b0, 12'h3F0, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    $display("test reset done");
    // Random settings, then reserved current codes that must not reach the outputs.
    for (i = 0; i < 4; i++)
    begin
      w = cfg(4'($urandom_range(0, 13)), 4'($urandom_range(0, 13)), 4'($urandom), 4'hF, 4'($urandom),
              4'($urandom)) | ($urandom & 32'h7F);
      apb(1'b1, `LCF_ADDR_SETUP_ONE, w);
      apb(1'b0, `LCF_ADDR_SETUP_ONE, 32'h0);
      `CHK("setup readback", w, q)
      `CHK("ilimit_ref", w[30:27], ilimit_ref)
      `CHK("comparator threshold", w[26:23], comparator_lock_threshold)
    end
    apb(1'b1, `LCF_ADDR_SETUP_ONE, {1'b0, 4'hE, 4'hF, w[22:0]});
    apb(1'b0, `LCF_ADDR_SETUP_ONE, 32'h0);
    `CHK("reserved ilimit", w[30:27], ilimit_ref)
    `CHK("reserved threshold", w[26:23], comparator_lock_threshold)
    $display("test settings done");
    // Every response mode on the comparator path, retry limit zero.
    apb(1'b1, `LCF_ADDR_ENABLE, 32'h1);
    // The comparator code output lags the setup by a cycle, so settle it before the first mode.
    apb(1'b1, `LCF_ADDR_SETUP_ONE, cfg(4'h3, 4'h5, 4'hF, 4'hF, 4'h0, 4'h0));
    for (m = 0; m < 16; m++)
    begin
      apb(1'b1, `LCF_ADDR_SETUP_ONE, cfg(4'h3, 4'h5, 4'hF, 4'(m), 4'h0, 4'h0));
      load <= 12'd400;
      tick(DEG + 1);
      @(negedge clk);
      `CHK("fault_out_n", !(m <= 8), fault_out_n)
      `CHK("gate_hiz", m < 2 || m == 4 || m == 5, gate_hiz)
      `CHK("brake_high", m == 2 || m == 6, brake_high)
      `CHK("brake_low", m == 3 || m == 7, brake_low)
      `CHK("irq", m <= 8, irq)
      @(posedge clk);
      load <= 12'h000;
      apb(1'b1, `LCF_ADDR_CTRL, 32'h1);
      apb(1'b1, `LCF_ADDR_CLEAR, 32'h7);
    end
    $display("test modes done");
    // Deglitch: a pulse one cycle short is ignored, a held lock counts; masked interrupt.
    apb(1'b1, `LCF_ADDR_ENABLE, 32'h0);
    apb(1'b1, `LCF_ADDR_SETUP_ONE, cfg(4'h3, 4'hF, 4'h9, 4'h0, 4'h2, 4'h0));
    load <= thr(4'h9);
    tick(4 * DEG - 1);
    load <= 12'h000;
    tick(4 * DEG + 2);
    @(negedge clk);
    `CHK("short pulse", 1'b1, fault_out_n)
    @(posedge clk);
    load <= thr(4'h9);
    tick(4 * DEG);
    @(negedge clk);
    `CHK("before deglitch end", 1'b1, fault_out_n)
    @(negedge clk);
    `CHK("after deglitch end", 1'b0, fault_out_n)
    `CHK("masked irq", 1'b0, irq)
    apb(1'b0, `LCF_ADDR_STATUS, 32'h0);
    `CHK("lock status", 1'b1, q[0])
    apb(1'b1, `LCF_ADDR_ENABLE, 32'h1);
    tick(2);
    @(negedge clk);
    `CHK("enabled irq", 1'b1, irq)
    apb(1'b1, `LCF_ADDR_CLEAR, 32'h7);
    load <= 12'h000;
    tick(2);
    @(negedge clk);
    `CHK("cleared irq", 1'b0, irq)
    apb(1'b1, `LCF_ADDR_CTRL, 32'h1);
    $display("test deglitch done");
    // ADC threshold boundary, report only mode.
    for (i = 0; i < 3; i++)
    begin
      c = 4'($urandom_range(0, 13));
      apb(1'b1, `LCF_ADDR_SETUP_ONE, cfg(4'h3, 4'hF, c, 4'h8, 4'h0, 4'h0));
      load <= thr(c) - 12'h001;
      tick(DEG + 2);
      @(negedge clk);
      `CHK("below threshold", 1'b1, fault_out_n)
      @(posedge clk);
      load <= thr(c);
      tick(DEG + 1);
      @(negedge clk);
      `CHK("at threshold", 1'b0, fault_out_n)
      @(posedge clk);
      load <= 12'h000;
      tick(2);
    end
    $display("test threshold done");
    // Auto retry: one retry, then latched; a control clear restores the retry.
    apb(1'b1, `LCF_ADDR_RETRY_LIM, 32'h1);
    apb(1'b0, `LCF_ADDR_RETRY_LIM, 32'h0);
    `CHK("retry limit", 32'h1, q)
    // First pass tristates, second pass brakes high.
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, `LCF_ADDR_SETUP_ONE, cfg(4'h3, 4'hF, 4'h9, (i == 0) ? 4'h4 : 4'h6, 4'h0, 4'h1));
      apb(1'b1, `LCF_ADDR_CLEAR, 32'h7);
      load <= thr(4'h9);
      tick(DEG + 1);
      @(negedge clk);
      `CHK("retry fault", 1'b0, fault_out_n)
      `CHK("retry hiz", i == 0, gate_hiz)
      `CHK("retry brake", i == 1, brake_high)
      k = 0;
      while (fault_out_n === 1'b0 && k < 200)
      begin
        @(negedge clk);
        k++;
      end
      `CHK("retry wait", 5 * RET, k)
      apb(1'b0, `LCF_ADDR_STATUS, 32'h0);
      `CHK("auto cleared", 1'b1, q[2])
      tick(5 * RET + 4);
      @(negedge clk);
      `CHK("latched fault", 1'b0, fault_out_n)
      apb(1'b0, `LCF_ADDR_STATUS, 32'h0);
      `CHK("latched status", 1'b1, q[1])
      load <= 12'h000;
      apb(1'b1, `LCF_ADDR_CTRL, 32'h1);
    end
    $display("test retry done");
    report_and_stop();
  end
endmodule // lcf_top_tb
